/* File: rtl/ssrc_core.sv */
// security send/receive command decoder with format completion
// assumes a command source with valid/ready, an executor for protocol payloads,
// a format engine, and a completion poster with valid/ready
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ssrc_core #(
	parameter logic [7:0] OPC_FORMAT     = 8'h01,
	parameter logic [7:0] OPC_SEC_SEND   = 8'h02,
	parameter logic [7:0] OPC_SEC_RECV   = 8'h03,
	parameter logic [7:0] SC_INVALID_OPC = 8'h01,
	parameter logic [7:0] SC_INVALID_FLD = 8'h02,
	parameter int         CNT_W          = 16
) (
	// clock and reset
	input  wire logic                      clk_in,
	input  wire logic                      srst_in,
	// register port
	input  wire logic [ssrc_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [ssrc_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                      reg_wr_in,
	input  wire logic                      reg_rd_in,
	output logic      [ssrc_pkg::DATA_W-1:0] reg_rdata_out,
	// admin command in
	input  wire logic                      cmd_valid_in,
	output logic                           cmd_ready_out,
	input  wire logic [7:0]                cmd_opcode_in,
	input  wire logic [15:0]               cmd_id_in,
	input  wire logic [63:0]               cmd_buf_pointer_first_in,
	input  wire logic [63:0]               cmd_buf_pointer_second_in,
	input  wire logic [31:0]               cmd_dword10_in,
	input  wire logic [31:0]               cmd_dword11_in,
	// format engine
	output logic                           fmt_start_out,
	output logic      [31:0]               fmt_dword10_out,
	input  wire logic                      fmt_done_in,
	input  wire logic                      fmt_invalid_in,
	// security executor
	output logic                           sec_req_valid_out,
	input  wire logic                      sec_req_done_in,
	input  wire logic [2:0]                sec_done_sct_in,
	input  wire logic [7:0]                sec_done_sc_in,
	output logic                           sec_is_receive_out,
	output logic                           sec_discovery_out,
	output logic                           sec_replay_block_out,
	output logic      [7:0]                sec_protocol_selector_out,
	output logic      [7:0]                sec_proto_specific_hi_out,
	output logic      [7:0]                sec_proto_specific_lo_out,
	output logic      [7:0]                sec_device_specific_target_out,
	output logic      [31:0]               sec_length_out,
	output logic      [63:0]               sec_buf_pointer_first_out,
	output logic      [63:0]               sec_buf_pointer_second_out,
	output logic      [255:0]              sec_support_map_out,
	output logic                           sec_result_pending_out,
	input  wire logic                      link_lost_in,
	// admin completion out
	output logic                           cpl_valid_out,
	input  wire logic                      cpl_ready_in,
	output logic      [15:0]               cpl_id_out,
	output logic      [2:0]                cpl_sct_out,
	output logic      [7:0]                cpl_sc_out
);
	import ssrc_pkg::*;

	if (CNT_W < 1 || CNT_W > DATA_W) begin : g_check
		$error("ssrc_core: CNT_W must be 1..DATA_W");
	end

	// ==================================================================
	// state and storage
	ssrc_state_t          state_reg;
	logic [255:0]         support_reg;
	logic [1:0]           control_reg;
	logic [CNT_W-1:0]     cpl_count_reg;
	logic [7:0]           opcode_reg;
	logic [15:0]          id_reg;
	logic [31:0]          dw10_reg;
	logic [31:0]          dw11_reg;
	logic [63:0]          ptr_first_reg;
	logic [63:0]          ptr_second_reg;
	logic                 fmt_busy_reg;
	logic                 fmt_pend_reg;
	logic                 fmt_bad_reg;
	logic [15:0]          fmt_id_reg;
	logic                 pending_reg;
	logic [7:0]           last_sc_reg;
	logic [15:0]          cpl_id_reg;
	logic [2:0]           cpl_sct_reg;
	logic [7:0]           cpl_sc_reg;
	logic [DATA_W-1:0]    rdata_reg;
	logic                 fmt_start_reg;

	// ==================================================================
	// decode of the latched command
	logic [7:0]  proto;
	logic [15:0] spec;
	logic        is_recv;
	logic        is_send;
	logic        proto_supported;
	logic        proto_bad;
	logic        spec_bad;
	logic        cmd_take;
	logic        fmt_post;
	logic        cpl_take;

	assign proto   = dw10_reg[PROTO_MSB:PROTO_LSB];
	assign spec    = {dw10_reg[SPEC_HI_MSB:SPEC_HI_LSB],
	                  dw10_reg[SPEC_LO_MSB:SPEC_LO_LSB]};
	assign is_recv = (opcode_reg == OPC_SEC_RECV);
	assign is_send = (opcode_reg == OPC_SEC_SEND);
	assign proto_supported = support_reg[proto];

	// discovery is receive only, so 00h counts as reserved for a send
	always_comb begin
		proto_bad = 1'b0;
		if (is_recv) begin
			proto_bad = !proto_supported || !control_reg[CTRL_RX_EN];
		end else if (is_send) begin
			proto_bad = !proto_supported || (proto == PROTO_DISCOVERY)
			            || !control_reg[CTRL_TX_EN];
		end
	end

	assign spec_bad = (proto == PROTO_DEVICE) && (spec != SPEC_REPLAY_BLOCK);

	// a finished format is posted only from idle so it never tramples a command
	assign fmt_post      = fmt_pend_reg && (state_reg == SSRC_IDLE);
	assign cmd_ready_out = (state_reg == SSRC_IDLE) && !fmt_pend_reg
	                       && !(fmt_busy_reg && cmd_opcode_in == OPC_FORMAT);
	assign cmd_take      = cmd_valid_in && cmd_ready_out;
	assign cpl_take      = cpl_valid_out && cpl_ready_in;

	// ==================================================================
	// command latch: the opcode, the id, the two pointers and dwords 10, 11 are kept
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			opcode_reg     <= 8'h00;
			id_reg         <= 16'h0000;
			dw10_reg       <= 32'h0000_0000;
			dw11_reg       <= 32'h0000_0000;
			ptr_first_reg  <= 64'h0;
			ptr_second_reg <= 64'h0;
		end else if (cmd_take) begin
			opcode_reg     <= cmd_opcode_in;
			id_reg         <= cmd_id_in;
			dw10_reg       <= cmd_dword10_in;
			dw11_reg       <= cmd_dword11_in;
			ptr_first_reg  <= cmd_buf_pointer_first_in;
			ptr_second_reg <= cmd_buf_pointer_second_in;
		end
	end

	// ==================================================================
	// main sequence
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_reg <= SSRC_IDLE;
		end else begin
			unique case (state_reg)
				SSRC_IDLE: begin
					if (fmt_post) begin
						state_reg <= SSRC_POST;
					end else if (cmd_take && cmd_opcode_in != OPC_FORMAT) begin
						state_reg <= SSRC_DECODE;
					end
				end
				SSRC_DECODE: begin
					if ((is_recv || is_send) && !proto_bad && !spec_bad) begin
						state_reg <= SSRC_EXEC;
					end else begin
						state_reg <= SSRC_POST;
					end
				end
				SSRC_EXEC: begin
					if (sec_req_done_in) begin
						state_reg <= SSRC_POST;
					end
				end
				SSRC_POST: begin
					if (cpl_take) begin
						state_reg <= SSRC_IDLE;
					end
				end
			endcase
		end
	end

	// ==================================================================
	// completion entry
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cpl_id_reg  <= 16'h0000;
			cpl_sct_reg <= SCT_GENERIC;
			cpl_sc_reg  <= SC_SUCCESS;
		end else if (fmt_post) begin
			cpl_id_reg <= fmt_id_reg;
			if (fmt_bad_reg) begin
				cpl_sct_reg <= SCT_CMD_SPECIFIC;
				cpl_sc_reg  <= SC_INVALID_FORMAT;
			end else begin
				cpl_sct_reg <= SCT_GENERIC;
				cpl_sc_reg  <= SC_SUCCESS;
			end
		end else if (state_reg == SSRC_DECODE) begin
			cpl_id_reg  <= id_reg;
			cpl_sct_reg <= SCT_GENERIC;
			if (!is_recv && !is_send) begin
				cpl_sc_reg <= SC_INVALID_OPC;
			end else if (proto_bad || spec_bad) begin
				cpl_sc_reg <= SC_INVALID_FLD;
			end else begin
				cpl_sc_reg <= SC_SUCCESS;
			end
		end else if (state_reg == SSRC_EXEC && sec_req_done_in) begin
			cpl_sct_reg <= sec_done_sct_in;
			cpl_sc_reg  <= sec_done_sc_in;
		end
	end

	assign cpl_valid_out = (state_reg == SSRC_POST);
	assign cpl_id_out    = cpl_id_reg;
	assign cpl_sct_out   = cpl_sct_reg;
	assign cpl_sc_out    = cpl_sc_reg;

	// ==================================================================
	// format tracking: done that lands while busy is held until idle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fmt_busy_reg  <= 1'b0;
			fmt_pend_reg  <= 1'b0;
			fmt_bad_reg   <= 1'b0;
			fmt_id_reg    <= 16'h0000;
			fmt_start_reg <= 1'b0;
		end else begin
			fmt_start_reg <= cmd_take && (cmd_opcode_in == OPC_FORMAT);
			if (cmd_take && cmd_opcode_in == OPC_FORMAT) begin
				fmt_busy_reg <= 1'b1;
				fmt_id_reg   <= cmd_id_in;
			end
			if (fmt_busy_reg && fmt_done_in) begin
				fmt_busy_reg <= 1'b0;
				fmt_pend_reg <= 1'b1;
				fmt_bad_reg  <= fmt_invalid_in;
			end else if (fmt_post) begin
				fmt_pend_reg <= 1'b0;
			end
		end
	end

	assign fmt_start_out   = fmt_start_reg;
	assign fmt_dword10_out = dw10_reg;

	// ==================================================================
	// send results await a receive; reset drops them, and so does link loss unless a send completes in that cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pending_reg <= 1'b0;
		end else if (state_reg == SSRC_EXEC && sec_req_done_in && is_send) begin
			pending_reg <= 1'b1;
		end else if (link_lost_in) begin
			pending_reg <= 1'b0;
		end else if (state_reg == SSRC_EXEC && sec_req_done_in && is_recv
		             && proto != PROTO_DISCOVERY) begin
			pending_reg <= 1'b0;
		end
	end

	// ==================================================================
	// executor request
	assign sec_req_valid_out              = (state_reg == SSRC_EXEC);
	assign sec_is_receive_out             = is_recv;
	assign sec_discovery_out              = is_recv && (proto == PROTO_DISCOVERY);
	assign sec_replay_block_out           = (proto == PROTO_DEVICE)
	                                        && (spec == SPEC_REPLAY_BLOCK);
	assign sec_protocol_selector_out      = proto;
	assign sec_proto_specific_hi_out      = spec[15:8];
	assign sec_proto_specific_lo_out      = spec[7:0];
	assign sec_device_specific_target_out = (proto == PROTO_DEVICE)
	                                        ? dw10_reg[TARGET_MSB:TARGET_LSB] : 8'h00;
	assign sec_length_out                 = dw11_reg;
	assign sec_buf_pointer_first_out      = ptr_first_reg;
	assign sec_buf_pointer_second_out     = ptr_second_reg;
	assign sec_support_map_out            = support_reg;
	assign sec_result_pending_out         = pending_reg;

	// ==================================================================
	// last status and completion counter
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			last_sc_reg   <= SC_SUCCESS;
			cpl_count_reg <= '0;
		end else if (cpl_take) begin
			last_sc_reg   <= cpl_sc_reg;
			cpl_count_reg <= cpl_count_reg + 1'b1;
		end
	end

	// ==================================================================
	// register writes: support map words and control
	for (genvar w = 0; w < SUPPORT_WORDS; w++) begin : g_support
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				support_reg[w*DATA_W +: DATA_W] <= SUPPORT_RESET[w*DATA_W +: DATA_W];
			end else if (reg_wr_in && reg_addr_in == REG_SUPPORT0 + 8'(w*4)) begin
				support_reg[w*DATA_W +: DATA_W] <= reg_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			control_reg <= CONTROL_RESET;
		end else if (reg_wr_in && reg_addr_in == REG_CONTROL) begin
			control_reg <= reg_wdata_in[1:0];
		end
	end

	// ==================================================================
	// register reads, data valid in the following cycle only
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_reg <= '0;
		end else if (reg_rd_in) begin
			if (reg_addr_in < REG_STATUS && reg_addr_in[1:0] == 2'h0) begin
				rdata_reg <= support_reg[reg_addr_in[4:2]*DATA_W +: DATA_W];
			end else if (reg_addr_in == REG_STATUS) begin
				rdata_reg <= {12'h000, last_sc_reg, 5'h00, cpl_valid_out,
				              pending_reg, fmt_pend_reg, fmt_busy_reg, 1'b0,
				              state_reg};
			end else if (reg_addr_in == REG_CPL_COUNT) begin
				rdata_reg <= DATA_W'(cpl_count_reg);
			end else if (reg_addr_in == REG_CONTROL) begin
				rdata_reg <= {30'h0, control_reg};
			end else begin
				rdata_reg <= '0;
			end
		end else begin
			rdata_reg <= '0;
		end
	end

	assign reg_rdata_out = rdata_reg;

endmodule : ssrc_core

`default_nettype wire

/* File: rtl/ssrc_pkg.sv */
// security command decoder package: register map, field layout, codes, states
// assumes admin commands are fetched and completions posted by logic outside
package ssrc_pkg;

	// ==================================================================
	// register map
	localparam int         ADDR_W          = 8;
	localparam int         DATA_W          = 32;
	localparam int         SUPPORT_WORDS   = 8;
	localparam logic [7:0] REG_SUPPORT0    = 8'h00;
	localparam logic [7:0] REG_STATUS      = 8'h20;
	localparam logic [7:0] REG_CPL_COUNT   = 8'h24;
	localparam logic [7:0] REG_CONTROL     = 8'h28;
	// protocols 00h and EAh are served after reset
	localparam logic [255:0] SUPPORT_RESET = 256'h1 | (256'h1 << 8'hea);
	localparam logic [1:0]   CONTROL_RESET = 2'h3;
	localparam int         CTRL_RX_EN      = 0;
	localparam int         CTRL_TX_EN      = 1;

	// ==================================================================
	// command dword 10 layout
	localparam int PROTO_MSB  = 31;
	localparam int PROTO_LSB  = 24;
	localparam int SPEC_HI_MSB = 23;
	localparam int SPEC_HI_LSB = 16;
	localparam int SPEC_LO_MSB = 15;
	localparam int SPEC_LO_LSB = 8;
	localparam int TARGET_MSB = 7;
	localparam int TARGET_LSB = 0;

	// ==================================================================
	// protocol values and status codes
	localparam logic [7:0]  PROTO_DISCOVERY   = 8'h00;
	localparam logic [7:0]  PROTO_DEVICE      = 8'hea;
	localparam logic [15:0] SPEC_REPLAY_BLOCK = 16'h0001;
	localparam logic [7:0]  SC_SUCCESS        = 8'h00;
	localparam logic [7:0]  SC_INVALID_FORMAT = 8'h0a;
	localparam logic [2:0]  SCT_GENERIC       = 3'h0;
	localparam logic [2:0]  SCT_CMD_SPECIFIC  = 3'h1;

	// ==================================================================
	// controller states, gray along idle-decode-exec-post
	typedef enum logic [1:0] {
		SSRC_IDLE   = 2'h0,
		SSRC_DECODE = 2'h1,
		SSRC_EXEC   = 2'h3,
		SSRC_POST   = 2'h2
	} ssrc_state_t;

endpackage : ssrc_pkg

/* File: tb/ssrc_core_sva.sv */
// assertions on the security command decoder ports
// assumes single clock domain clk_in with synchronous reset srst_in
`timescale 1ns/1ps
`default_nettype none

module ssrc_core_sva #(
	parameter logic [7:0] OPC_FORMAT = 8'h01
) (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        srst_in,
	// command side
	input wire logic        cmd_valid_in,
	input wire logic        cmd_ready_out,
	input wire logic [7:0]  cmd_opcode_in,
	input wire logic [31:0] cmd_dword10_in,
	input wire logic [31:0] cmd_dword11_in,
	// format and executor side
	input wire logic        fmt_start_out,
	input wire logic        fmt_done_in,
	input wire logic        fmt_invalid_in,
	input wire logic        sec_req_valid_out,
	input wire logic        sec_req_done_in,
	input wire logic [7:0]  sec_done_sc_in,
	input wire logic        sec_is_receive_out,
	input wire logic        sec_discovery_out,
	input wire logic        sec_replay_block_out,
	input wire logic [7:0]  sec_protocol_selector_out,
	input wire logic [7:0]  sec_proto_specific_hi_out,
	input wire logic [7:0]  sec_proto_specific_lo_out,
	input wire logic [7:0]  sec_device_specific_target_out,
	input wire logic [31:0] sec_length_out,
	// completion side
	input wire logic        cpl_valid_out,
	input wire logic        cpl_ready_in,
	input wire logic [15:0] cpl_id_out,
	input wire logic [2:0]  cpl_sct_out,
	input wire logic [7:0]  cpl_sc_out
);
	import ssrc_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// ==================================================================
	// sequences
	sequence s_take_sec;
		cmd_valid_in && cmd_ready_out && cmd_opcode_in != OPC_FORMAT;
	endsequence
	sequence s_exec_entry;
		s_take_sec ##2 sec_req_valid_out;
	endsequence

	// ==================================================================
	// properties
	property p_fmt_start;
		cmd_valid_in && cmd_ready_out && cmd_opcode_in == OPC_FORMAT |=> fmt_start_out;
	endproperty
	a_fmt_start: assert property (p_fmt_start) else $error("format start missing");
	property p_fmt_bad;
		fmt_done_in && fmt_invalid_in |-> ##[1:20] cpl_valid_out
			&& cpl_sct_out == SCT_CMD_SPECIFIC && cpl_sc_out == SC_INVALID_FORMAT;
	endproperty
	a_fmt_bad: assert property (p_fmt_bad) else $error("invalid format status missing");
	property p_fields;
		s_exec_entry |-> sec_length_out == $past(cmd_dword11_in, 2) && {sec_protocol_selector_out,
			sec_proto_specific_hi_out, sec_proto_specific_lo_out} == $past(cmd_dword10_in[31:8], 2);
	endproperty
	a_fields: assert property (p_fields) else $error("decoded fields wrong");
	property p_target;
		sec_req_valid_out && sec_protocol_selector_out != PROTO_DEVICE
			|-> sec_device_specific_target_out == 8'h00;
	endproperty
	a_target: assert property (p_target) else $error("target passed for other protocol");
	property p_replay;
		sec_req_valid_out |-> sec_replay_block_out == (sec_protocol_selector_out == PROTO_DEVICE
			&& {sec_proto_specific_hi_out, sec_proto_specific_lo_out} == SPEC_REPLAY_BLOCK);
	endproperty
	a_replay: assert property (p_replay) else $error("replay block flag wrong");
	property p_discovery;
		sec_req_valid_out |-> sec_discovery_out
			== (sec_is_receive_out && sec_protocol_selector_out == PROTO_DISCOVERY);
	endproperty
	a_discovery: assert property (p_discovery) else $error("discovery flag wrong");
	property p_done_post;
		sec_req_valid_out && sec_req_done_in |=> cpl_valid_out && cpl_sc_out == $past(sec_done_sc_in);
	endproperty
	a_done_post: assert property (p_done_post) else $error("completion not posted");
	property p_cpl_hold;
		cpl_valid_out && !cpl_ready_in |=> cpl_valid_out && $stable(cpl_id_out) && $stable(cpl_sc_out);
	endproperty
	a_cpl_hold: assert property (p_cpl_hold) else $error("completion dropped early");
endmodule : ssrc_core_sva

bind ssrc_core ssrc_core_sva #(.OPC_FORMAT(OPC_FORMAT)) u_sva (.*);

`default_nettype wire

/* File: tb/ssrc_exec_model.sv */
// executor and format engine model answering the decoder
// assumes lat_in is at least 1 when a format is started
`timescale 1ns/1ps
`default_nettype none

module ssrc_exec_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	// scenario controls
	input  wire logic [3:0] lat_in,
	input  wire logic       fmt_bad_in,
	input  wire logic [7:0] sc_in,
	// decoder side
	input  wire logic       sec_req_valid_in,
	input  wire logic       fmt_start_in,
	output logic            sec_req_done_out,
	output logic [2:0]      sec_done_sct_out,
	output logic [7:0]      sec_done_sc_out,
	output logic            fmt_done_out,
	output logic            fmt_invalid_out
);
	logic [3:0] sec_cnt_reg;
	logic [3:0] fmt_cnt_reg;

	// protocol work finishes lat_in + 1 cycles after the request is seen, results handed back
	always_ff @(posedge clk_in) begin
		sec_req_done_out <= 1'b0;
		if (srst_in || !sec_req_valid_in || sec_req_done_out)
			sec_cnt_reg <= 4'h0;
		else if (sec_cnt_reg == lat_in)
			sec_req_done_out <= 1'b1;
		else
			sec_cnt_reg <= sec_cnt_reg + 4'h1;
	end
	// status lines only meaningful with done
	assign sec_done_sct_out = sec_req_done_out ? 3'h0 : 3'h7;
	assign sec_done_sc_out  = sec_req_done_out ? sc_in : ~sc_in;

	always_ff @(posedge clk_in) begin
		if (srst_in)
			fmt_cnt_reg <= 4'h0;
		else if (fmt_start_in)
			fmt_cnt_reg <= lat_in;
		else if (fmt_cnt_reg != 4'h0)
			fmt_cnt_reg <= fmt_cnt_reg - 4'h1;
		fmt_done_out <= !srst_in && fmt_cnt_reg == 4'h1;
	end
	assign fmt_invalid_out = fmt_done_out ? fmt_bad_in : !fmt_bad_in;
endmodule : ssrc_exec_model

`default_nettype wire

/* File: tb/test_security_send_receive_cmds.sv */
// self-checking bench for the security command decoder
// assumes ssrc_exec_model as executor and format engine
`timescale 1ns/1ps
`default_nettype none

module test_security_send_receive_cmds;
	import ssrc_pkg::*;
	localparam logic [7:0] OP_FMT = 8'h01;
	localparam logic [7:0] OP_TX  = 8'h02;
	localparam logic [7:0] OP_RX  = 8'h03;
	localparam logic [7:0] SC_OPC = 8'h01;
	localparam logic [7:0] SC_FLD = 8'h02;
	typedef struct packed {
		logic [7:0]  op;
		logic [31:0] dw10;
		logic [7:0]  sc;
	} ssrc_row_t;
	localparam ssrc_row_t ROWS [8] = '{
		'{OP_RX, 32'h0000_005a, 8'h00},
		'{OP_TX, 32'hea00_0105, 8'h00},
		'{OP_RX, 32'hea00_0107, 8'h00},
		'{OP_TX, 32'h0000_0000, SC_FLD},
		'{OP_RX, 32'h0500_0000, SC_FLD},
		'{OP_RX, 32'hea00_0200, SC_FLD},
		'{OP_TX, 32'heaff_ff00, SC_FLD},
		'{8'h7f, 32'hea00_0100, SC_OPC}};

	logic clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00, cmd_opcode_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, cmd_dword10_in = 32'h0;
	logic [31:0] cmd_dword11_in = 32'h0, fmt_dword10_out, sec_length_out;
	logic cmd_valid_in = 1'b0, cmd_ready_out, fmt_start_out, fmt_done_in, fmt_invalid_in;
	logic [15:0] cmd_id_in = 16'h0, cpl_id_out;
	logic [63:0] cmd_buf_pointer_first_in = 64'h0, cmd_buf_pointer_second_in = 64'h0;
	logic [63:0] sec_buf_pointer_first_out, sec_buf_pointer_second_out;
	logic sec_req_valid_out, sec_req_done_in, sec_is_receive_out, sec_discovery_out;
	logic sec_replay_block_out, sec_result_pending_out, cpl_valid_out;
	logic [2:0] sec_done_sct_in, cpl_sct_out;
	logic [7:0] sec_done_sc_in, cpl_sc_out, sec_protocol_selector_out;
	logic [7:0] sec_proto_specific_hi_out, sec_proto_specific_lo_out;
	logic [7:0] sec_device_specific_target_out;
	logic [255:0] sec_support_map_out;
	logic link_lost_in = 1'b0, cpl_ready_in = 1'b0, fmt_bad = 1'b0, r_ex;
	logic [3:0] lat = 4'h2;
	logic [7:0] ex_sc = 8'h00;
	logic [2:0] r_sct;
	logic [7:0] r_sc;
	logic [15:0] r_id;
	int n_mismatch = 0, compares = 0;

	always #10 clk_in = !clk_in;

	ssrc_core #(.OPC_FORMAT(OP_FMT), .OPC_SEC_SEND(OP_TX), .OPC_SEC_RECV(OP_RX),
		.SC_INVALID_OPC(SC_OPC), .SC_INVALID_FLD(SC_FLD)) u_dut (.*);
	ssrc_exec_model u_exec (.clk_in(clk_in), .srst_in(srst_in), .lat_in(lat),
		.fmt_bad_in(fmt_bad), .sc_in(ex_sc), .sec_req_valid_in(sec_req_valid_out),
		.fmt_start_in(fmt_start_out), .sec_req_done_out(sec_req_done_in),
		.sec_done_sct_out(sec_done_sct_in), .sec_done_sc_out(sec_done_sc_in),
		.fmt_done_out(fmt_done_in), .fmt_invalid_out(fmt_invalid_in));

	// ==================================================================
	// tasks
	task automatic conclude();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(64'(reg_rdata_out), 64'(exp));
	endtask : reg_rd

	// issues one command, checks the executor view, stalls and takes the completion
	task automatic run_cmd(input logic [7:0] op, input logic [31:0] d10, input logic [15:0] id);
		r_ex = 1'b0;
		@(posedge clk_in);
		cmd_valid_in <= 1'b1;
		cmd_opcode_in <= op;
		cmd_id_in <= id;
		cmd_dword10_in <= d10;
		cmd_dword11_in <= {d10[15:0], id};
		cmd_buf_pointer_first_in <= {32'h1000_0000, d10};
		cmd_buf_pointer_second_in <= {d10, 32'h2000_0000};
		do @(negedge clk_in); while (cmd_ready_out !== 1'b1);
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		cmd_dword10_in <= ~d10;
		do begin
			@(negedge clk_in);
			if (sec_req_valid_out === 1'b1 && !r_ex) begin
				r_ex = 1'b1;
				chk(sec_buf_pointer_first_out, {32'h1000_0000, d10});
				chk(sec_buf_pointer_second_out, {d10, 32'h2000_0000});
				chk({sec_length_out, sec_device_specific_target_out, sec_is_receive_out},
					{d10[15:0], id, (d10[31:24] == 8'hea) ? d10[7:0] : 8'h00,
					op == OP_RX});
			end
		end while (cpl_valid_out !== 1'b1);
		r_sct = cpl_sct_out;
		r_sc = cpl_sc_out;
		r_id = cpl_id_out;
		@(posedge clk_in);
		cpl_ready_in <= 1'b1;
		@(posedge clk_in);
		cpl_ready_in <= 1'b0;
	endtask : run_cmd

	// ==================================================================
	// sequence
	initial begin
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		reg_rd(REG_SUPPORT0, 32'h1);
		reg_rd(REG_SUPPORT0 + 8'h1c, 32'h400);
		reg_rd(REG_CONTROL, 32'h3);
		reg_rd(8'h40, 32'h0);
		$display("test reset values done");
		foreach (ROWS[i]) begin
			run_cmd(ROWS[i].op, ROWS[i].dw10, 16'(i));
			chk({r_ex, r_sct, r_sc, r_id}, {ROWS[i].sc == 8'h00, 3'h0, ROWS[i].sc, 16'(i)});
		end
		reg_rd(REG_CPL_COUNT, 32'h8);
		$display("test command table done");
		lat <= 4'h3;
		run_cmd(OP_FMT, 32'h0000_0012, 16'h00f0);
		chk({r_ex, r_sct, r_sc, r_id, fmt_dword10_out}, {1'b0, 3'h0, 8'h00, 16'h00f0, 32'h12});
		fmt_bad <= 1'b1;
		run_cmd(OP_FMT, 32'h0000_0017, 16'h00f1);
		chk({r_sct, r_sc, r_id}, {SCT_CMD_SPECIFIC, SC_INVALID_FORMAT, 16'h00f1});
		$display("test format done");
		reg_wr(REG_CONTROL, 32'h2);
		run_cmd(OP_RX, 32'hea00_0100, 16'h0031);
		chk({r_ex, r_sc}, {1'b0, SC_FLD});
		reg_wr(REG_CONTROL, 32'h3);
		lat <= 4'h9;
		ex_sc <= 8'h6d;
		run_cmd(OP_TX, 32'hea00_0103, 16'h0032);
		chk({r_ex, r_sc, sec_result_pending_out}, {1'b1, 8'h6d, 1'b1});
		@(posedge clk_in);
		link_lost_in <= 1'b1;
		@(posedge clk_in);
		link_lost_in <= 1'b0;
		@(negedge clk_in);
		chk(64'(sec_result_pending_out), 64'h0);
		run_cmd(OP_TX, 32'hea00_0103, 16'h0033);
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		@(negedge clk_in);
		chk({sec_result_pending_out, cpl_valid_out, cmd_ready_out}, 3'h1);
		reg_rd(REG_CPL_COUNT, 32'h0);
		$display("test pending and reset done");
		reg_wr(REG_SUPPORT0, 32'h21);
		@(negedge clk_in);
		chk(sec_support_map_out[63:0], 64'h21);
		reg_rd(REG_SUPPORT0, 32'h21);
		run_cmd(OP_RX, 32'h0500_0000, 16'h0041);
		chk({r_ex, r_sc}, {1'b1, 8'h6d});
		reg_wr(REG_CONTROL, 32'h1);
		run_cmd(OP_TX, 32'hea00_0100, 16'h0042);
		chk({r_ex, r_sc}, {1'b0, SC_FLD});
		$display("test support map and enables done");
		conclude();
	end

	initial begin
		repeat (5000) @(posedge clk_in);
		n_mismatch++;
		conclude();
	end
endmodule : test_security_send_receive_cmds

`default_nettype wire
